// [rtl/bsr_pkg.sv]
package bsr_pkg;
	localparam int IR_W = 4;
	localparam logic [3:0] INS_EXTEST = 4'h0;
	localparam logic [3:0] INS_DEFAULT = 4'h1;
	localparam logic [3:0] INS_SAMPLE = 4'h2;
	localparam logic [3:0] INS_CORE_RESET = 4'hc;
	localparam logic [3:0] INS_BYPASS = 4'hf;
	localparam logic [3:0] IR_CAPTURE = 4'h1;

	typedef enum logic [3:0] {
		BSR_TLR = 4'h0, BSR_RTI = 4'h1, BSR_SEL_DR = 4'h2, BSR_CAP_DR = 4'h3,
		BSR_SH_DR = 4'h4, BSR_EX1_DR = 4'h5, BSR_PA_DR = 4'h6, BSR_EX2_DR = 4'h7,
		BSR_UPD_DR = 4'h8, BSR_SEL_IR = 4'h9, BSR_CAP_IR = 4'ha, BSR_SH_IR = 4'hb,
		BSR_EX1_IR = 4'hc, BSR_PA_IR = 4'hd, BSR_EX2_IR = 4'he, BSR_UPD_IR = 4'hf
	} bsr_tap_t;

	typedef enum logic [1:0] {
		BSR_DR_BYPASS = 2'h0, BSR_DR_RESET = 2'h1, BSR_DR_CHAIN = 2'h2
	} bsr_dr_t;

	// Chain positions, bit 0 nearest data out
	localparam int CMP_OFF = 0;
	localparam int CMP_MUX = 1;
	localparam int CMP_BG = 2;
	localparam int CMP_RES = 3;
	localparam int OSC_EXT_EN = 4;
	localparam int OSC_EXT_CK = 5;
	localparam int OSC_XT_EN = 6;
	localparam int OSC_XT_CK = 7;
	localparam int OSC_LF_EN = 8;
	localparam int OSC_LF_CK = 9;
	localparam int RST_NORM = 10;
	localparam int RST_HV = 11;
	localparam int PIN_BASE = 12;
	localparam int PIN_STRIDE = 3;
	localparam int PIN_PUE = 0;
	localparam int PIN_OC = 1;
	localparam int PIN_ODID = 2;

	localparam logic EXT_CK_UNUSED = 1'b0;
	localparam logic XT_CK_UNUSED = 1'b1;
	localparam logic LF_CK_UNUSED = 1'b1;

	// Register map
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_PIN_OUT = 8'h04;
	localparam logic [7:0] REG_PIN_DIR = 8'h08;
	localparam logic [7:0] REG_PIN_LEVEL = 8'h0c;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam int CTRL_PUD = 0;
	localparam int CTRL_EXT_EN = 1;
	localparam int CTRL_XT_EN = 2;
	localparam int CTRL_LF_EN = 3;
	localparam int CTRL_CMP_OFF = 4;
	localparam int CTRL_CMP_MUX = 5;
	localparam int CTRL_CMP_BG = 6;
	localparam int CTRL_W = 7;
	localparam logic [6:0] CTRL_RESET = 7'h10;
	localparam int ST_TAP = 0;
	localparam int ST_IR = 4;
	localparam int ST_CORE_RST = 8;
	localparam int ST_CMP = 9;

	function automatic bsr_dr_t bsr_decode(input logic [3:0] ir);
		if (ir == INS_CORE_RESET) begin
			return BSR_DR_RESET;
		end
		if (ir == INS_EXTEST || ir == INS_SAMPLE) begin
			return BSR_DR_CHAIN;
		end
		return BSR_DR_BYPASS;
	endfunction
endpackage

// [rtl/bsr_sync.sv]
module bsr_sync #(
	parameter int W = 1
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} bsr_sync_t;

	bsr_sync_t r;
	bsr_sync_t n;

	always_comb begin
		n.s1 = d;
		n.s2 = r.s1;
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign q = r.s2;
endmodule

// [rtl/bsr_tap_fsm.sv]
module bsr_tap_fsm (
	input wire logic mclk,
	input wire logic rst,
	input wire logic tck_rise,
	input wire logic tms,
	output bsr_pkg::bsr_tap_t state
);
	typedef struct packed {
		bsr_pkg::bsr_tap_t st;
	} bsr_fsm_t;

	bsr_fsm_t r;
	bsr_fsm_t n;

	always_comb begin
		n = r;
		if (tck_rise) begin
			unique case (r.st)
				bsr_pkg::BSR_TLR: n.st = tms ? bsr_pkg::BSR_TLR : bsr_pkg::BSR_RTI;
				bsr_pkg::BSR_RTI: n.st = tms ? bsr_pkg::BSR_SEL_DR : bsr_pkg::BSR_RTI;
				bsr_pkg::BSR_SEL_DR: n.st = tms ? bsr_pkg::BSR_SEL_IR : bsr_pkg::BSR_CAP_DR;
				bsr_pkg::BSR_CAP_DR: n.st = tms ? bsr_pkg::BSR_EX1_DR : bsr_pkg::BSR_SH_DR;
				bsr_pkg::BSR_SH_DR: n.st = tms ? bsr_pkg::BSR_EX1_DR : bsr_pkg::BSR_SH_DR;
				bsr_pkg::BSR_EX1_DR: n.st = tms ? bsr_pkg::BSR_UPD_DR : bsr_pkg::BSR_PA_DR;
				bsr_pkg::BSR_PA_DR: n.st = tms ? bsr_pkg::BSR_EX2_DR : bsr_pkg::BSR_PA_DR;
				bsr_pkg::BSR_EX2_DR: n.st = tms ? bsr_pkg::BSR_UPD_DR : bsr_pkg::BSR_SH_DR;
				bsr_pkg::BSR_UPD_DR: n.st = tms ? bsr_pkg::BSR_SEL_DR : bsr_pkg::BSR_RTI;
				bsr_pkg::BSR_SEL_IR: n.st = tms ? bsr_pkg::BSR_TLR : bsr_pkg::BSR_CAP_IR;
				bsr_pkg::BSR_CAP_IR: n.st = tms ? bsr_pkg::BSR_EX1_IR : bsr_pkg::BSR_SH_IR;
				bsr_pkg::BSR_SH_IR: n.st = tms ? bsr_pkg::BSR_EX1_IR : bsr_pkg::BSR_SH_IR;
				bsr_pkg::BSR_EX1_IR: n.st = tms ? bsr_pkg::BSR_UPD_IR : bsr_pkg::BSR_PA_IR;
				bsr_pkg::BSR_PA_IR: n.st = tms ? bsr_pkg::BSR_EX2_IR : bsr_pkg::BSR_PA_IR;
				bsr_pkg::BSR_EX2_IR: n.st = tms ? bsr_pkg::BSR_UPD_IR : bsr_pkg::BSR_SH_IR;
				bsr_pkg::BSR_UPD_IR: n.st = tms ? bsr_pkg::BSR_SEL_DR : bsr_pkg::BSR_RTI;
			endcase
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			r.st <= bsr_pkg::BSR_TLR;
		end else begin
			r <= n;
		end
	end

	assign state = r.st;
endmodule

// [rtl/bsr_top.sv]
module bsr_top #(
	parameter int NPINS = 8
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo,
	input wire logic [NPINS-1:0] pin_in,
	output logic [NPINS-1:0] pin_out,
	output logic [NPINS-1:0] pin_oe_n,
	output logic [NPINS-1:0] pin_pullup_enable,
	input wire logic reset_pin_n,
	input wire logic hv_reset_pin,
	input wire logic external_clock_line,
	input wire logic crystal_osc_clock,
	input wire logic low_freq_osc_clock,
	output logic external_clock_enable,
	output logic crystal_osc_enable,
	output logic low_freq_osc_enable,
	input wire logic comparator_result,
	output logic comparator_off,
	output logic comparator_mux_select,
	output logic comparator_bandgap_enable,
	output logic core_comparator_result,
	output logic core_reset,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata
);
	localparam int CW = bsr_pkg::PIN_BASE + bsr_pkg::PIN_STRIDE * NPINS;
	localparam int SW = NPINS + 9;

	generate
		if (NPINS < 1 || NPINS > 32) begin : g_bad_npins
			$error("NPINS must lie in 1..32");
		end
	endgenerate

	typedef struct packed {
		logic tck_d;
		logic [3:0] ir;
		logic [3:0] ir_sh;
		logic rst_dr;
		logic byp;
		logic [CW-1:0] bs_sh;
		logic [CW-1:0] bs_up;
		logic tdo;
		logic ap_wr;
		logic [7:0] ap_addr;
		logic hreadyout;
		logic [31:0] hrdata;
		logic [6:0] ctrl;
		logic [NPINS-1:0] pout;
		logic [NPINS-1:0] pdir;
		logic [NPINS-1:0] pin_out;
		logic [NPINS-1:0] pin_oe_n;
		logic [NPINS-1:0] pup;
		logic ext_en;
		logic xt_en;
		logic lf_en;
		logic c_off;
		logic c_mux;
		logic c_bg;
		logic core_cmp;
	} bsr_st_t;

	bsr_st_t r;
	bsr_st_t n;

	logic [SW-1:0] sync_q;
	logic s_tck;
	logic s_tms;
	logic s_tdi;
	logic [NPINS-1:0] s_pin;
	logic s_rstn;
	logic s_hv;
	logic s_extck;
	logic s_xtck;
	logic s_lfck;
	logic s_cmp;
	logic tck_rise;
	logic tck_fall;
	bsr_pkg::bsr_tap_t tap;

	bsr_sync #(.W(SW)) u_sync (
		.mclk(mclk),
		.rst(rst),
		.d({tck, tms, tdi, pin_in, reset_pin_n, hv_reset_pin, external_clock_line, crystal_osc_clock,
			low_freq_osc_clock, comparator_result}),
		.q(sync_q)
	);

	assign {s_tck, s_tms, s_tdi, s_pin, s_rstn, s_hv, s_extck, s_xtck, s_lfck, s_cmp} = sync_q;
	assign tck_rise = s_tck & ~r.tck_d;
	assign tck_fall = ~s_tck & r.tck_d;

	bsr_tap_fsm u_fsm (
		.mclk(mclk),
		.rst(rst),
		.tck_rise(tck_rise),
		.tms(s_tms),
		.state(tap)
	);

	function automatic logic [31:0] bsr_read(input bsr_st_t v, input logic [7:0] a, input logic [3:0] st,
		input logic [NPINS-1:0] lvl, input logic cmp);
		logic [31:0] d;
		d = 32'h0;
		unique case (a)
			bsr_pkg::REG_CTRL: d[6:0] = v.ctrl;
			bsr_pkg::REG_PIN_OUT: d[NPINS-1:0] = v.pout;
			bsr_pkg::REG_PIN_DIR: d[NPINS-1:0] = v.pdir;
			bsr_pkg::REG_PIN_LEVEL: d[NPINS-1:0] = lvl;
			bsr_pkg::REG_STATUS: begin
				d[bsr_pkg::ST_TAP +: 4] = st;
				d[bsr_pkg::ST_IR +: 4] = v.ir;
				d[bsr_pkg::ST_CORE_RST] = v.rst_dr;
				d[bsr_pkg::ST_CMP] = cmp;
			end
			default: d = 32'h0;
		endcase
		return d;
	endfunction

	always_comb begin
		logic [CW-1:0] cap;
		bsr_pkg::bsr_dr_t sel;
		logic extest;
		logic take;
		logic dr_out;
		cap = '0;
		dr_out = 1'b0;
		sel = bsr_pkg::bsr_decode(r.ir);
		extest = (r.ir == bsr_pkg::INS_EXTEST);
		take = hsel & hready & htrans[1];
		n = r;
		n.tck_d = s_tck;

		// Capture values for the boundary chain
		for (int i = 0; i < NPINS; i++) begin
			cap[bsr_pkg::PIN_BASE + bsr_pkg::PIN_STRIDE * i + bsr_pkg::PIN_PUE] =
				~r.ctrl[bsr_pkg::CTRL_PUD] & ~r.pdir[i] & r.pout[i];
			cap[bsr_pkg::PIN_BASE + bsr_pkg::PIN_STRIDE * i + bsr_pkg::PIN_OC] = r.pin_oe_n[i] == 1'b0;
			cap[bsr_pkg::PIN_BASE + bsr_pkg::PIN_STRIDE * i + bsr_pkg::PIN_ODID] = s_pin[i];
		end
		cap[bsr_pkg::RST_NORM] = s_rstn;
		cap[bsr_pkg::RST_HV] = s_hv;
		// Internal RC clock has no cell
		cap[bsr_pkg::OSC_EXT_EN] = r.ext_en;
		cap[bsr_pkg::OSC_EXT_CK] = r.ext_en ? s_extck : bsr_pkg::EXT_CK_UNUSED;
		cap[bsr_pkg::OSC_XT_EN] = r.xt_en;
		cap[bsr_pkg::OSC_XT_CK] = r.xt_en ? s_xtck : bsr_pkg::XT_CK_UNUSED;
		cap[bsr_pkg::OSC_LF_EN] = r.lf_en;
		cap[bsr_pkg::OSC_LF_CK] = r.lf_en ? s_lfck : bsr_pkg::LF_CK_UNUSED;
		cap[bsr_pkg::CMP_OFF] = r.c_off;
		cap[bsr_pkg::CMP_MUX] = r.c_mux;
		cap[bsr_pkg::CMP_BG] = r.c_bg;
		cap[bsr_pkg::CMP_RES] = s_cmp;

		// Test port actions on the test clock rising edge only
		if (tck_rise) begin
			if (tap == bsr_pkg::BSR_TLR) begin
				n.ir = bsr_pkg::INS_DEFAULT;
			end
			if (tap == bsr_pkg::BSR_CAP_IR) begin
				n.ir_sh = bsr_pkg::IR_CAPTURE;
			end
			if (tap == bsr_pkg::BSR_SH_IR) begin
				n.ir_sh = {s_tdi, r.ir_sh[3:1]};
			end
			if (tap == bsr_pkg::BSR_UPD_IR) begin
				n.ir = r.ir_sh;
			end
			if (tap == bsr_pkg::BSR_CAP_DR) begin
				if (sel == bsr_pkg::BSR_DR_BYPASS) begin
					n.byp = 1'b0;
				end
				if (sel == bsr_pkg::BSR_DR_CHAIN) begin
					n.bs_sh = cap;
				end
			end
			if (tap == bsr_pkg::BSR_SH_DR) begin
				unique case (sel)
					bsr_pkg::BSR_DR_RESET: n.rst_dr = s_tdi;
					bsr_pkg::BSR_DR_BYPASS: n.byp = s_tdi;
					bsr_pkg::BSR_DR_CHAIN: n.bs_sh = {s_tdi, r.bs_sh[CW-1:1]};
					default: n.byp = s_tdi;
				endcase
			end
			if (tap == bsr_pkg::BSR_UPD_DR && sel == bsr_pkg::BSR_DR_CHAIN) begin
				n.bs_up = r.bs_sh;
			end
		end

		// Data out changes on the falling edge
		unique case (sel)
			bsr_pkg::BSR_DR_RESET: dr_out = r.rst_dr;
			bsr_pkg::BSR_DR_CHAIN: dr_out = r.bs_sh[0];
			default: dr_out = r.byp;
		endcase
		if (tck_fall) begin
			if (tap == bsr_pkg::BSR_SH_IR) begin
				n.tdo = r.ir_sh[0];
			end
			if (tap == bsr_pkg::BSR_SH_DR) begin
				n.tdo = dr_out;
			end
		end

		// Bus write in data phase, then read from the updated copy
		n.hreadyout = 1'b1;
		n.ap_wr = take & hwrite;
		n.ap_addr = haddr[7:0];
		if (r.ap_wr) begin
			if (r.ap_addr == bsr_pkg::REG_CTRL) begin
				n.ctrl = hwdata[6:0];
			end
			if (r.ap_addr == bsr_pkg::REG_PIN_OUT) begin
				n.pout = hwdata[NPINS-1:0];
			end
			if (r.ap_addr == bsr_pkg::REG_PIN_DIR) begin
				n.pdir = hwdata[NPINS-1:0];
			end
		end
		n.hrdata = (take & ~hwrite) ? bsr_read(n, haddr[7:0], tap, s_pin, r.core_cmp) : 32'h0;

		// Pins and analog/oscillator controls, from the chain in extest
		for (int i = 0; i < NPINS; i++) begin
			if (extest) begin
				n.pin_out[i] = r.bs_up[bsr_pkg::PIN_BASE + bsr_pkg::PIN_STRIDE * i + bsr_pkg::PIN_ODID];
				n.pin_oe_n[i] = ~r.bs_up[bsr_pkg::PIN_BASE + bsr_pkg::PIN_STRIDE * i + bsr_pkg::PIN_OC];
				n.pup[i] = r.bs_up[bsr_pkg::PIN_BASE + bsr_pkg::PIN_STRIDE * i + bsr_pkg::PIN_PUE];
			end else begin
				n.pin_out[i] = n.pout[i];
				n.pin_oe_n[i] = ~n.pdir[i] | r.rst_dr;
				n.pup[i] = ~n.ctrl[bsr_pkg::CTRL_PUD] & ~n.pdir[i] & n.pout[i] & ~r.rst_dr;
			end
		end
		if (extest) begin
			n.ext_en = r.bs_up[bsr_pkg::OSC_EXT_EN];
			n.xt_en = r.bs_up[bsr_pkg::OSC_XT_EN];
			n.lf_en = r.bs_up[bsr_pkg::OSC_LF_EN];
			n.c_off = r.bs_up[bsr_pkg::CMP_OFF];
			n.c_mux = r.bs_up[bsr_pkg::CMP_MUX];
			n.c_bg = r.bs_up[bsr_pkg::CMP_BG];
			n.core_cmp = r.bs_up[bsr_pkg::CMP_RES];
		end else begin
			n.ext_en = n.ctrl[bsr_pkg::CTRL_EXT_EN];
			n.xt_en = n.ctrl[bsr_pkg::CTRL_XT_EN];
			n.lf_en = n.ctrl[bsr_pkg::CTRL_LF_EN];
			n.c_off = n.ctrl[bsr_pkg::CTRL_CMP_OFF];
			n.c_mux = n.ctrl[bsr_pkg::CTRL_CMP_MUX];
			n.c_bg = n.ctrl[bsr_pkg::CTRL_CMP_BG];
			n.core_cmp = s_cmp;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			r <= '0;
			r.ir <= bsr_pkg::INS_DEFAULT;
			r.hreadyout <= 1'b1;
			r.ctrl <= bsr_pkg::CTRL_RESET;
			r.c_off <= 1'b1;
			r.pin_oe_n <= '1;
		end else begin
			r <= n;
		end
	end

	// Reset register drives the core straight, no update stage
	assign core_reset = r.rst_dr;
	assign tdo = r.tdo;
	assign pin_out = r.pin_out;
	assign pin_oe_n = r.pin_oe_n;
	assign pin_pullup_enable = r.pup;
	assign external_clock_enable = r.ext_en;
	assign crystal_osc_enable = r.xt_en;
	assign low_freq_osc_enable = r.lf_en;
	assign comparator_off = r.c_off;
	assign comparator_mux_select = r.c_mux;
	assign comparator_bandgap_enable = r.c_bg;
	assign core_comparator_result = r.core_cmp;
	assign hreadyout = r.hreadyout;
	assign hresp = 1'b0;
	assign hrdata = r.hrdata;
endmodule

// [testbench/bsrbc_jtag_host.sv]
module bsrbc_jtag_host (
	output logic tck,
	output logic tms,
	output logic tdi,
	input wire logic tdo
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end
	// One period; tdo read late since it settles well after the fall
	task automatic tick(input logic m, input logic d, output logic o);
		tms = m;
		tdi = d;
		#200 tck = 1'b1;
		#195 o = tdo;
		#5 tck = 1'b0;
	endtask
	// From idle through one IR or DR scan back to idle
	task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
		logic o;
		dout = 32'h0;
		#17;
		tick(1'b0, tdi, o);
		tick(1'b1, tdi, o);
		if (ir) begin
			tick(1'b1, tdi, o);
		end
		tick(1'b0, tdi, o);
		tick(1'b0, tdi, o);
		for (int i = 0; i < n; i++) begin
			tick(i == n - 1, din[i], o);
			dout[i] = o;
		end
		tick(1'b1, ~din[n - 1], o);
		tick(1'b0, ~din[n - 1], o);
	endtask
endmodule

// [testbench/bsrbc_properties.sv]
module bsrbc_properties #(
	parameter int NPINS = 8
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic tck,
	input wire logic tdo,
	input wire logic [NPINS-1:0] pin_out,
	input wire logic [NPINS-1:0] pin_oe_n,
	input wire logic [NPINS-1:0] pin_pullup_enable,
	input wire logic comparator_off,
	input wire logic core_reset,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	logic rd_ph;
	logic tck_d;
	logic [3:0] quiet;
	// Cycles since the last bus request or test clock edge
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rd_ph <= 1'b0;
			tck_d <= 1'b0;
			quiet <= 4'h0;
		end else begin
			rd_ph <= hsel && hready && htrans[1] && !hwrite;
			tck_d <= tck;
			if ((hsel && hready && htrans[1]) || tck != tck_d) begin
				quiet <= 4'h0;
			end else if (quiet != 4'hf) begin
				quiet <= quiet + 4'h1;
			end
		end
	end
	bus_okay_a: assert property (hresp == 1'b0)
		else $error("hresp not okay");
	bus_ready_a: assert property (hreadyout == 1'b1)
		else $error("hreadyout low");
	rdata_idle_a: assert property (!rd_ph |-> hrdata == 32'h0)
		else $error("hrdata outside read data phase");
	tdo_on_fall_a: assert property ($changed(tdo) |-> !$past(tck, 2))
		else $error("tdo moved without a test clock fall");
	core_rst_tck_a: assert property ($changed(core_reset) |-> $past(tck, 2))
		else $error("core reset moved without a test clock rise");
	pullup_input_a: assert property ((pin_pullup_enable & ~pin_oe_n) == '0)
		else $error("pull-up on a driven pin");
	core_tristate_a: assert property ($rose(core_reset) |-> ##[0:2] (&pin_oe_n))
		else $error("pins still driven in core reset");
	reset_state_a: assert property ($fell(rst) |-> comparator_off && !core_reset && (&pin_oe_n) && !tdo)
		else $error("wrong state after reset");
	quiet_outputs_a: assert property (quiet >= 4'h8 |-> $stable(pin_out) && $stable(pin_oe_n)
		&& $stable(pin_pullup_enable) && $stable(comparator_off) && $stable(core_reset) && $stable(tdo))
		else $error("output moved with no cause");
endmodule

// [testbench/tb_boundary_scan_reset_bypass_cells.sv]
module tb_boundary_scan_reset_bypass_cells;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int NP = 4;
	localparam int CHAIN = 12 + 3 * NP;
	localparam int LIMIT = 20000;
	typedef struct {
		logic [7:0] addr;
		logic wr;
		logic [31:0] data;
	} bsrbc_row_t;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic tck, tms, tdi, tdo, hsel, hwrite, hready, hreadyout, hresp;
	logic [NP-1:0] pin_in, pin_out, pin_oe_n, pin_pullup_enable;
	logic reset_pin_n, hv_reset_pin, external_clock_line, crystal_osc_clock, low_freq_osc_clock;
	logic external_clock_enable, crystal_osc_enable, low_freq_osc_enable, comparator_result, core_reset;
	logic comparator_off, comparator_mux_select, comparator_bandgap_enable, core_comparator_result;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, rd, dout, exp;
	int fails = 0;
	int checks = 0;
	int cycles = 0;
	bsrbc_row_t rows [14] = '{
		'{8'h00, 1'b0, 32'h10}, '{8'h00, 1'b1, 32'h02}, '{8'h00, 1'b0, 32'h02}, '{8'h04, 1'b1, 32'h05},
		'{8'h08, 1'b1, 32'h03}, '{8'h04, 1'b0, 32'h05}, '{8'h08, 1'b0, 32'h03}, '{8'h40, 1'b1, 32'hffffffff},
		'{8'h40, 1'b0, 32'h00}, '{8'h10, 1'b1, 32'hffff}, '{8'h10, 1'b0, 32'h10}, '{8'h0c, 1'b0, 32'h0a},
		'{8'h00, 1'b1, 32'h10}, '{8'h00, 1'b0, 32'h10}};
	assign hready = hreadyout;
	bsr_top #(.NPINS(NP)) DUT (.mclk, .rst, .tck, .tms, .tdi, .tdo, .pin_in, .pin_out, .pin_oe_n, .pin_pullup_enable,
		.reset_pin_n, .hv_reset_pin, .external_clock_line, .crystal_osc_clock, .low_freq_osc_clock,
		.external_clock_enable, .crystal_osc_enable, .low_freq_osc_enable, .comparator_result, .comparator_off,
		.comparator_mux_select, .comparator_bandgap_enable, .core_comparator_result, .core_reset, .hsel, .haddr,
		.htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata);
	bsrbc_jtag_host host (.tck, .tms, .tdi, .tdo);
	always #25 mclk = ~mclk;
	always @(posedge mclk) begin
		cycles++;
		if (cycles == LIMIT) begin
			fails++;
			stop_test();
		end
	end
	task automatic check(input string what, input logic [31:0] want, input logic [31:0] got);
		checks++;
		if (got !== want) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", what, want, got);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd);
		@(posedge mclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge mclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge mclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask
	initial begin
		pin_in = 4'ha;
		reset_pin_n = 1'b1;
		hv_reset_pin = 1'b1;
		external_clock_line = 1'b0;
		crystal_osc_clock = 1'b1;
		low_freq_osc_clock = 1'b1;
		comparator_result = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		hwrite = 1'b0;
		htrans = 2'h0;
		hsize = 3'h2;
		hwdata = 32'h0;
		repeat (16) @(posedge mclk);
		rst <= 1'b0;
		foreach (rows[i]) begin
			ahb(rows[i].addr, rows[i].wr, rows[i].data);
			if (!rows[i].wr) begin
				check("register read", rows[i].data, rd);
			end
		end
		for (int k = 0; k < 2; k++) begin
			ahb(8'h00, 1'b1, k ? 32'h10 : 32'h65);
			repeat (2) @(posedge mclk);
			#1;
			check("control outputs", k ? 32'h04 : 32'h13, 32'({external_clock_enable, crystal_osc_enable,
				low_freq_osc_enable, comparator_off, comparator_mux_select, comparator_bandgap_enable}));
			check("pull-up", k ? 32'h4 : 32'h0, 32'(pin_pullup_enable));
		end
		check("pin drive", 32'hc5, 32'({pin_oe_n, pin_out}));
		host.scan(1'b1, 4, 32'hc, dout);
		check("ir capture", 32'h1, dout);
		host.scan(1'b0, 1, 32'h1, dout);
		check("reset bit old", 32'h0, dout);
		#1;
		check("core reset", 32'h1f, 32'({core_reset, pin_oe_n}));
		host.scan(1'b0, 2, 32'h3, dout);
		check("reset bit held", 32'h3, dout);
		ahb(8'h10, 1'b0, 32'h0);
		check("status", 32'h1c1, rd);
		// Reset in mid-run while the core is held
		rst <= 1'b1;
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		#1;
		check("after reset", 32'h1f, 32'({core_reset, comparator_off, pin_oe_n}));
		ahb(8'h10, 1'b0, 32'h0);
		check("status reset", 32'h10, rd);
		for (int k = 0; k < 2; k++) begin
			host.scan(1'b1, 4, k ? 32'h5 : 32'hf, dout);
			host.scan(1'b0, 4, 32'hb, dout);
			check("bypass", 32'h6, dout);
		end
		ahb(8'h04, 1'b1, 32'h5);
		ahb(8'h08, 1'b1, 32'h3);
		comparator_result <= 1'b1;
		external_clock_line <= 1'b1;
		crystal_osc_clock <= 1'b0;
		low_freq_osc_clock <= 1'b0;
		hv_reset_pin <= 1'b0;
		host.scan(1'b1, 4, 32'h2, dout);
		host.scan(1'b0, CHAIN + 1, 32'h1, dout);
		exp = 32'h689 | (32'h1 << CHAIN);
		for (int i = 0; i < NP; i++) begin
			exp |= 32'({pin_in[i], i < 2, i == 2}) << (12 + 3 * i);
		end
		check("boundary chain", exp, dout);
		check("core comparator", 32'h1, 32'(core_comparator_result));
		// Preload the chain, then drive the pins and controls from it
		host.scan(1'b0, CHAIN, 32'h56012, dout);
		host.scan(1'b1, 4, 32'h0, dout);
		#1;
		check("extest pins", 32'h4c1, 32'({pin_pullup_enable, pin_oe_n, pin_out}));
		check("extest controls", 32'h22, 32'({external_clock_enable, crystal_osc_enable, low_freq_osc_enable,
			comparator_off, comparator_mux_select, comparator_bandgap_enable}));
		check("extest comparator", 32'h0, 32'(core_comparator_result));
		host.scan(1'b0, CHAIN, 32'h56012, dout);
		check("extest chain", (exp & 32'hfff000) | 32'h6ba, dout);
		stop_test();
	end
endmodule
bind bsr_top bsrbc_properties #(.NPINS(NPINS)) props (.mclk, .rst, .tck, .tdo, .pin_out, .pin_oe_n,
	.pin_pullup_enable, .comparator_off, .core_reset, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata);
